// ### hw/wdb_pkg.sv
// shared constants and types for the dead-band waveform register block
package wdb_pkg;

  // ****************************************
  // register indexes (byte address is four times the index)
  // ****************************************
  localparam logic [11:0] IDX_CLK  = 12'h60C;
  localparam logic [11:0] IDX_ISM  = 12'h60D;
  localparam logic [11:0] IDX_DBR  = 12'h60E;
  localparam logic [11:0] IDX_DBF  = 12'h60F;
  localparam logic [11:0] IDX_CON0 = 12'h610;
  localparam logic [11:0] IDX_CON1 = 12'h611;
  localparam logic [11:0] IDX_AS0  = 12'h612;
  localparam logic [11:0] IDX_AS1  = 12'h613;
  localparam logic [11:0] IDX_STR  = 12'h614;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int DB_W         = 6;
  localparam int ISM_W        = 5;
  localparam int CON0_EN_BIT  = 7;
  localparam int CON0_LD_BIT  = 6;
  localparam int CON1_IN_BIT  = 5;
  localparam int AS0_SD_BIT   = 7;
  localparam int AS0_REN_BIT  = 6;
  localparam int AS0_PAIR_BD_SHUTDOWN_STATE_LSB = 4;
  localparam int AS0_PAIR_AC_SHUTDOWN_STATE_LSB = 2;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [1:0]      LS_RST_BD = 2'h1;
  localparam logic [1:0]      LS_RST_AC = 2'h1;
  localparam logic [DB_W-1:0] DB_POR    = 6'h00;

  // ****************************************
  // modes and shutdown states
  // ****************************************
  localparam logic [2:0] MODE_STEER      = 3'h0;
  localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
  localparam logic [2:0] MODE_HALF       = 3'h4;
  localparam logic [1:0] LS_INACT        = 2'h0;
  localparam logic [1:0] LS_TRI          = 2'h1;
  localparam logic [1:0] LS_LOW          = 2'h2;
  localparam logic [1:0] LS_HIGH         = 2'h3;

  typedef enum logic [2:0] {
    DB_OFF  = 3'b001,
    DB_WAIT = 3'b010,
    DB_ON   = 3'b100
  } wdb_db_e;

endpackage

// ### hw/wdb_dead_band.sv
// one edge-triggered dead-band delay stage
`timescale 1ns/1ps
`default_nettype none

module wdb_dead_band (
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire logic                   tick,
  input  wire logic                   lvl,
  input  wire logic [wdb_pkg::DB_W-1:0] count,
  output logic                        active
);

  typedef struct packed {
    wdb_pkg::wdb_db_e         state;
    logic [wdb_pkg::DB_W-1:0] cnt;
    logic                     act;
  } wdb_db_s;

  wdb_db_s s_r;
  wdb_db_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      wdb_pkg::DB_OFF: begin
        if (lvl) begin
          if (count == '0) begin
            s_nxt.state = wdb_pkg::DB_ON;
          end else begin
            s_nxt.state = wdb_pkg::DB_WAIT;
            s_nxt.cnt   = count;
          end
        end
      end
      wdb_pkg::DB_WAIT: begin
        if (!lvl) begin
          s_nxt.state = wdb_pkg::DB_OFF;
        end else if (tick) begin
          if (s_r.cnt <= 6'h01) begin
            s_nxt.state = wdb_pkg::DB_ON;
          end else begin
            s_nxt.cnt = s_r.cnt - 6'h01;
          end
        end
      end
      wdb_pkg::DB_ON: begin
        if (!lvl) begin
          s_nxt.state = wdb_pkg::DB_OFF;
        end
      end
      default: begin
        s_nxt.state = wdb_pkg::DB_OFF;
      end
    endcase
    s_nxt.act = (s_nxt.state == wdb_pkg::DB_ON);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{state: wdb_pkg::DB_OFF, cnt: '0, act: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active = s_r.act;

  // ****************************************
  // checks
  // ****************************************
  zero_bypass_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.state == wdb_pkg::DB_OFF && lvl && count == '0) |=> active)
    else $error("zero count did not bypass delay");

  count_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.state == wdb_pkg::DB_OFF && lvl && count != '0)
      |=> (s_r.state == wdb_pkg::DB_WAIT && s_r.cnt == $past(count) && !active))
    else $error("delay count not loaded on edge");

  count_expiry_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.state == wdb_pkg::DB_WAIT && lvl && tick && s_r.cnt == 6'h01) |=> active)
    else $error("output late after delay expiry");

  no_early_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.state == wdb_pkg::DB_WAIT && s_r.cnt > 6'h01) |=> !active)
    else $error("output switched before delay expired");

endmodule

`default_nettype wire

// ### hw/wdb_top.sv
// dead-band waveform generator with its apb register map
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - rising edge delay: n to n+1 periods
// - falling edge delay: n to n+1 periods
// - zero count bypasses the delay
// - power-on reset clears both counts to zero
// - other resets keep both counts
// - six-bit counts, upper two bits unimplemented
// - source select one: fast internal clock
// - inactive shutdown state waits for dead band
module wdb_top #(
  parameter int ADDR_W = 16,
  parameter int SRC_N  = 18
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              soft_rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [SRC_N-1:0]  data_src,
  input  wire logic [7:0]        shut_src,
  input  wire logic              sys_tick,
  output logic [3:0]             out_lvl,
  output logic [3:0]             out_drv_n
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [SRC_N-1:0]         ds1;
    logic [SRC_N-1:0]         ds2;
    logic [SRC_N-1:0]         ds3;
    logic [SRC_N-1:0]         din_st;
    logic [7:0]               ss1;
    logic [7:0]               ss2;
    logic [7:0]               ss3;
    logic [7:0]               sh_st;
    logic                     cs;
    logic [wdb_pkg::ISM_W-1:0] ism;
    logic [wdb_pkg::DB_W-1:0] rising_delay_count;
    logic [wdb_pkg::DB_W-1:0] dbf;
    logic                     en;
    logic                     ld;
    logic [2:0]               mode;
    logic [3:0]               pol;
    logic                     sd;
    logic                     sd_hold;
    logic                     ren;
    logic [1:0]               pair_bd_shutdown_state;
    logic [1:0]               pair_ac_shutdown_state;
    logic [7:0]               as_en;
    logic [3:0]               ovr;
    logic [3:0]               str;
    logic                     din_d;
    logic                     pready;
    logic [31:0]              prdata;
    logic                     pslverr;
    logic [3:0]               out_lvl;
    logic [3:0]               out_drv_n;
  } wdb_top_s;

  localparam wdb_top_s RST_S = '{
    pair_bd_shutdown_state:    wdb_pkg::LS_RST_BD,
    pair_ac_shutdown_state:    wdb_pkg::LS_RST_AC,
    rising_delay_count:     wdb_pkg::DB_POR,
    dbf:     wdb_pkg::DB_POR,
    default: '0
  };

  wdb_top_s s_r;
  wdb_top_s s_nxt;

  // ****************************************
  // helpers
  // ****************************************
  // a bit moves only once stages two and three agree
  function automatic logic [31:0] settle(input logic [31:0] a,
                                         input logic [31:0] b,
                                         input logic [31:0] keep);
    return (a & b) | (keep & (a | b));
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // ****************************************
  // data path signals
  // ****************************************
  logic       din;
  logic       tick;
  logic       sh_event;
  logic       shut_act;
  logic       db_in;
  logic       rise_ok;
  logic       fall_ok;
  logic       acc;
  logic       mapped;
  logic [31:0] rd_val;
  logic [3:0] raw;

  always_comb begin
    din      = (32'(s_r.ism) < 32'(SRC_N)) ? s_r.din_st[s_r.ism] : 1'b0;
    tick     = s_r.cs ? 1'b1 : sys_tick;
    sh_event = |(s_r.sh_st & s_r.as_en);
    shut_act = s_r.sd | s_r.sd_hold;
    // shutdown drives the delay stages low so the falling delay still runs
    db_in    = din & s_r.en & ~shut_act;
  end

  wdb_dead_band u_rise (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (tick),
    .lvl      (db_in),
    .count    (s_r.rising_delay_count),
    .active   (rise_ok)
  );

  wdb_dead_band u_fall (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (tick),
    .lvl      (~db_in),
    .count    (s_r.dbf),
    .active   (fall_ok)
  );

  // ****************************************
  // register read decode
  // ****************************************
  always_comb begin
    acc    = psel & penable;
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (hit(paddr, wdb_pkg::IDX_CLK)) begin
      rd_val[0] = s_r.cs;
    end else if (hit(paddr, wdb_pkg::IDX_ISM)) begin
      rd_val[wdb_pkg::ISM_W-1:0] = s_r.ism;
    end else if (hit(paddr, wdb_pkg::IDX_DBR)) begin
      rd_val[wdb_pkg::DB_W-1:0] = s_r.rising_delay_count;
    end else if (hit(paddr, wdb_pkg::IDX_DBF)) begin
      rd_val[wdb_pkg::DB_W-1:0] = s_r.dbf;
    end else if (hit(paddr, wdb_pkg::IDX_CON0)) begin
      rd_val[wdb_pkg::CON0_EN_BIT] = s_r.en;
      rd_val[wdb_pkg::CON0_LD_BIT] = s_r.ld;
      rd_val[2:0]                  = s_r.mode;
    end else if (hit(paddr, wdb_pkg::IDX_CON1)) begin
      rd_val[wdb_pkg::CON1_IN_BIT] = din;
      rd_val[3:0]                  = s_r.pol;
    end else if (hit(paddr, wdb_pkg::IDX_AS0)) begin
      rd_val[wdb_pkg::AS0_SD_BIT]                           = s_r.sd;
      rd_val[wdb_pkg::AS0_REN_BIT]                          = s_r.ren;
      rd_val[wdb_pkg::AS0_PAIR_BD_SHUTDOWN_STATE_LSB+1:wdb_pkg::AS0_PAIR_BD_SHUTDOWN_STATE_LSB] = s_r.pair_bd_shutdown_state;
      rd_val[wdb_pkg::AS0_PAIR_AC_SHUTDOWN_STATE_LSB+1:wdb_pkg::AS0_PAIR_AC_SHUTDOWN_STATE_LSB] = s_r.pair_ac_shutdown_state;
    end else if (hit(paddr, wdb_pkg::IDX_AS1)) begin
      rd_val[7:0] = s_r.as_en;
    end else if (hit(paddr, wdb_pkg::IDX_STR)) begin
      rd_val[7:0] = {s_r.ovr, s_r.str};
    end else begin
      mapped = 1'b0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [1:0] ls;
    logic       wr;
    ls    = 2'h0;
    wr    = 1'b0;
    s_nxt = s_r;

    // input synchronisers
    s_nxt.ds1    = data_src;
    s_nxt.ds2    = s_r.ds1;
    s_nxt.ds3    = s_r.ds2;
    s_nxt.din_st = SRC_N'(settle(32'(s_r.ds2), 32'(s_r.ds3), 32'(s_r.din_st)));
    s_nxt.ss1    = shut_src;
    s_nxt.ss2    = s_r.ss1;
    s_nxt.ss3    = s_r.ss2;
    s_nxt.sh_st  = 8'(settle(32'(s_r.ss2), 32'(s_r.ss3), 32'(s_r.sh_st)));
    s_nxt.din_d  = din;

    // apb: one wait cycle so read data leave a flip-flop
    s_nxt.pready = acc & ~s_r.pready;
    if (acc && !s_r.pready) begin
      s_nxt.prdata  = rd_val;
      s_nxt.pslverr = ~mapped;
    end else if (!acc) begin
      s_nxt.pslverr = 1'b0;
    end
    wr = acc & s_r.pready & pwrite & mapped;

    if (wr && hit(paddr, wdb_pkg::IDX_CLK)) begin
      s_nxt.cs = pwdata[0];
    end
    if (wr && hit(paddr, wdb_pkg::IDX_ISM)) begin
      s_nxt.ism = pwdata[wdb_pkg::ISM_W-1:0];
    end
    if (wr && hit(paddr, wdb_pkg::IDX_DBR)) begin
      s_nxt.rising_delay_count = pwdata[wdb_pkg::DB_W-1:0];
    end
    if (wr && hit(paddr, wdb_pkg::IDX_DBF)) begin
      s_nxt.dbf = pwdata[wdb_pkg::DB_W-1:0];
    end
    if (wr && hit(paddr, wdb_pkg::IDX_CON0)) begin
      s_nxt.en   = pwdata[wdb_pkg::CON0_EN_BIT];
      s_nxt.ld   = pwdata[wdb_pkg::CON0_LD_BIT];
      s_nxt.mode = pwdata[2:0];
    end else if (s_r.ld && din && !s_r.din_d) begin
      s_nxt.ld = 1'b0;
    end
    if (wr && hit(paddr, wdb_pkg::IDX_CON1)) begin
      s_nxt.pol = pwdata[3:0];
    end
    if (wr && hit(paddr, wdb_pkg::IDX_AS0)) begin
      s_nxt.sd   = pwdata[wdb_pkg::AS0_SD_BIT];
      s_nxt.ren  = pwdata[wdb_pkg::AS0_REN_BIT];
      s_nxt.pair_bd_shutdown_state = pwdata[wdb_pkg::AS0_PAIR_BD_SHUTDOWN_STATE_LSB+1:wdb_pkg::AS0_PAIR_BD_SHUTDOWN_STATE_LSB];
      s_nxt.pair_ac_shutdown_state = pwdata[wdb_pkg::AS0_PAIR_AC_SHUTDOWN_STATE_LSB+1:wdb_pkg::AS0_PAIR_AC_SHUTDOWN_STATE_LSB];
    end else if (s_r.ren && s_r.sd && !sh_event) begin
      s_nxt.sd = 1'b0;
    end
    if (wr && hit(paddr, wdb_pkg::IDX_AS1)) begin
      s_nxt.as_en = pwdata[7:0];
    end
    if (wr && hit(paddr, wdb_pkg::IDX_STR)) begin
      s_nxt.ovr = pwdata[7:4];
      s_nxt.str = pwdata[3:0];
    end

    // a shutdown event wins over a clear in the same cycle
    if (sh_event) begin
      s_nxt.sd = 1'b1;
    end
    // outputs stay shut until the next rising data edge after clearing
    if (s_r.sd) begin
      s_nxt.sd_hold = 1'b1;
    end else if (din && !s_r.din_d) begin
      s_nxt.sd_hold = 1'b0;
    end

    // output stage
    if (s_r.mode[2:1] == 2'b00) begin
      raw = s_r.str & {4{din}};
    end else begin
      raw = {fall_ok, rise_ok, fall_ok, rise_ok};
    end
    for (int i = 0; i < 4; i++) begin
      s_nxt.out_drv_n[i] = 1'b0;
      if (!s_r.en) begin
        s_nxt.out_lvl[i] = s_r.pol[i];
      end else if (s_r.mode[2:1] == 2'b00 && !s_r.str[i]) begin
        s_nxt.out_lvl[i] = s_r.ovr[i];
      end else begin
        s_nxt.out_lvl[i] = raw[i] ^ s_r.pol[i];
      end
      if (shut_act) begin
        ls = i[0] ? s_r.pair_bd_shutdown_state : s_r.pair_ac_shutdown_state;
        case (ls)
          wdb_pkg::LS_HIGH: s_nxt.out_lvl[i] = 1'b1;
          wdb_pkg::LS_LOW:  s_nxt.out_lvl[i] = 1'b0;
          wdb_pkg::LS_TRI: begin
            s_nxt.out_lvl[i]   = 1'b0;
            s_nxt.out_drv_n[i] = 1'b1;
          end
          default: begin
            s_nxt.out_lvl[i] = fall_ok ? s_r.pol[i] : s_r.out_lvl[i];
          end
        endcase
      end
    end

    // other resets keep both delay counts
    if (!soft_rstn) begin
      s_nxt     = RST_S;
      s_nxt.rising_delay_count = s_r.rising_delay_count;
      s_nxt.dbf = s_r.dbf;
      s_nxt.ds1 = s_r.ds1;
      s_nxt.ds2 = s_r.ds2;
      s_nxt.ds3 = s_r.ds3;
      s_nxt.ss1 = s_r.ss1;
      s_nxt.ss2 = s_r.ss2;
      s_nxt.ss3 = s_r.ss3;
    end
  end

  // counts reset to zero (DB_POR) at power-on; software must program them
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= RST_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready    = s_r.pready;
  assign prdata    = s_r.prdata;
  assign pslverr   = s_r.pslverr;
  assign out_lvl   = s_r.out_lvl;
  assign out_drv_n = s_r.out_drv_n;

  // ****************************************
  // checks
  // ****************************************
  counts_kept_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !soft_rstn |=> (s_r.rising_delay_count == $past(s_r.rising_delay_count) && s_r.dbf == $past(s_r.dbf)))
    else $error("soft reset disturbed delay counts");

  upper_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (acc && !s_r.pready && (hit(paddr, wdb_pkg::IDX_DBR) || hit(paddr, wdb_pkg::IDX_DBF)))
      |=> (s_r.prdata[31:6] == 26'h0 && pready))
    else $error("count register upper bits not zero");

  fast_tick_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ($rose(db_in) && s_r.cs) |-> ##[1:64] (rise_ok || !db_in || !s_r.cs))
    else $error("fast clock source did not run the delay");

  shut_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (sh_event && soft_rstn) |=> s_r.sd)
    else $error("shutdown event lost");

  inact_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (shut_act && s_r.en && s_r.pair_ac_shutdown_state == wdb_pkg::LS_INACT && !fall_ok && soft_rstn)
      |=> (s_r.out_lvl[0] == $past(s_r.out_lvl[0])))
    else $error("output changed before shutdown dead band");

  ready_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (acc && !s_r.pready && soft_rstn) |=> (pready ##1 !pready))
    else $error("apb ready not a one cycle answer");

endmodule

`default_nettype wire

// ### tb/wdb_switch_model.sv
// load model: a pair of power switch drivers on the generator outputs
`timescale 1ns/1ps
`default_nettype none

module wdb_switch_model (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] out_lvl,
  input  wire logic [3:0] out_drv_n,
  output logic [3:0]      pin,
  output int              overlap_cnt
);
  // a released pin sinks to the gate pull-down, never the last level
  assign pin = out_lvl & ~out_drv_n;

  // both switches of the a/b leg on at once would short the supply
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      overlap_cnt <= 0;
    end else if (pin[0] && pin[1]) begin
      overlap_cnt <= overlap_cnt + 1;
    end
  end
endmodule

`default_nettype wire

// ### tb/waveform_dead_band_regs_test.sv
// self-checking bench for the dead-band waveform register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end

module waveform_dead_band_regs_test;
  logic        core_clk = 0;
  logic        rstn = 0;
  logic        soft_rstn = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        sys_tick = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [0:0]  data_src = '0;
  logic [16:0] data_rnd = '0;
  logic [7:0]  shut_src = '0;
  logic [3:0]  out_lvl;
  logic [3:0]  out_drv_n;
  logic [3:0]  pin;
  int          overlap_cnt;
  int          err_total = 0;
  int          comparisons = 0;
  int          seed = 32'h3d441320;
  bit          tick_on = 1;
  int          mdl[int];
  logic [31:0] rd;
  logic        er;
  int          d;
  int          n;
  int          hi;

  always #2 core_clk = ~core_clk;

  // unused sources and the slow tick wander so their logic is exercised
  always @(posedge core_clk) begin
    sys_tick <= tick_on ? 1'($random(seed)) : 1'b0;
    data_rnd <= 17'($random(seed));
  end

  wdb_top dut (.core_clk(core_clk), .rstn(rstn), .soft_rstn(soft_rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .data_src({data_rnd, data_src}), .shut_src(shut_src),
    .sys_tick(sys_tick), .out_lvl(out_lvl), .out_drv_n(out_drv_n));

  wdb_switch_model load (.core_clk(core_clk), .rstn(rstn), .out_lvl(out_lvl),
    .out_drv_n(out_drv_n), .pin(pin), .overlap_cnt(overlap_cnt));

  // ****************************************
  // closing report and bus tasks
  // ****************************************
  task final_report;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task apb(input logic [11:0] idx, input logic [1:0] sub, input logic w,
           input logic [31:0] wd);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {2'b00, idx, sub};
    pwrite <= w;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      err_total++;
      final_report();
    end
  endtask

  function automatic int msk(input logic [11:0] idx);
    case (idx)
      wdb_pkg::IDX_CLK: return 32'h01;
      wdb_pkg::IDX_ISM: return 32'h1F;
      wdb_pkg::IDX_DBR, wdb_pkg::IDX_DBF: return 32'h3F;
      default: return 32'hFF;
    endcase
  endfunction

  task wr(input logic [11:0] idx, input logic [31:0] wd);
    apb(idx, 2'h0, 1'b1, wd);
    mdl[idx] = wd & msk(idx);
  endtask

  task rdc(input logic [11:0] idx);
    apb(idx, 2'h0, 1'b0, 32'h0);
    `CHK({er, rd}, {1'b0, 32'(mdl[idx])})
  endtask

  // drive the selected data input, count cycles until output b turns on
  task meas(input logic lvl, input int b);
    @(posedge core_clk);
    data_src[0] <= lvl;
    d = 0;
    do begin
      @(negedge core_clk);
      d++;
    end while (out_lvl[b] !== 1'b1 && d < 200);
    if (d >= 200) begin
      err_total++;
      final_report();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    wr(wdb_pkg::IDX_DBR, 32'hFF);
    rdc(wdb_pkg::IDX_DBR);
    apb(12'h615, 2'h0, 1'b0, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(wdb_pkg::IDX_DBF, 2'h1, 1'b0, 32'h0);
    `CHK(er, 1'b1)
    wr(wdb_pkg::IDX_CLK, 32'h01);
    rdc(wdb_pkg::IDX_CLK);
    wr(wdb_pkg::IDX_ISM, 32'h00);
    wr(wdb_pkg::IDX_CON1, 32'h00);
    wr(wdb_pkg::IDX_CON0, 32'h84);
    // sync 3..4 edges, n+1 count edges, one output edge; one more allowed
    for (int k = 0; k < 6; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? 63 : ($random(seed) & 63);
      wr(wdb_pkg::IDX_DBR, n);
      wr(wdb_pkg::IDX_DBF, n);
      meas(1'b1, 0);
      `CHK((d - n) >= 5 && (d - n) <= 7, 1'b1)
      meas(1'b0, 1);
      `CHK((d - n) >= 5 && (d - n) <= 7, 1'b1)
    end
    `CHK(overlap_cnt, 0)
    // a pulse shorter than the count must never reach output a
    wr(wdb_pkg::IDX_DBR, 32'h0C);
    @(posedge core_clk);
    data_src[0] <= 1'b1;
    repeat (5) @(posedge core_clk);
    data_src[0] <= 1'b0;
    hi = 0;
    repeat (40) @(negedge core_clk) if (out_lvl[0] !== 1'b0) hi++;
    `CHK(hi, 0)
    // slow source with no ticks: the count must stall
    tick_on = 0;
    wr(wdb_pkg::IDX_CLK, 32'h00);
    wr(wdb_pkg::IDX_DBR, 32'h02);
    @(posedge core_clk);
    data_src[0] <= 1'b1;
    hi = 0;
    repeat (30) @(negedge core_clk) if (out_lvl[0] !== 1'b0) hi++;
    `CHK(hi, 0)
    tick_on = 1;
    wr(wdb_pkg::IDX_CLK, 32'h01);
    meas(1'b1, 0);
    // shutdown to the inactive level, then to tri-state
    wr(wdb_pkg::IDX_AS1, 32'h01);
    wr(wdb_pkg::IDX_AS0, 32'h00);
    shut_src[0] <= 1'b1;
    hi = 0;
    while (out_lvl !== 4'h0 && hi < 100) @(negedge core_clk) hi++;
    if (hi >= 100) begin
      err_total++;
      final_report();
    end
    `CHK({out_lvl, out_drv_n}, 8'h00)
    apb(wdb_pkg::IDX_AS0, 2'h0, 1'b0, 32'h0);
    `CHK(rd[7], 1'b1)
    wr(wdb_pkg::IDX_AS0, 32'h94);
    repeat (4) @(negedge core_clk);
    `CHK(out_drv_n, 4'hF)
    @(posedge core_clk);
    shut_src[0] <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(wdb_pkg::IDX_AS0, 32'h00);
    // shutdown holds until a rising data edge, so take the data low first
    @(posedge core_clk);
    data_src[0] <= 1'b0;
    repeat (8) @(posedge core_clk);
    meas(1'b1, 0);
    `CHK(out_drv_n, 4'h0)
    // steering: b and d follow the data, a and c take their override bits
    wr(wdb_pkg::IDX_CON0, 32'hC0);
    rdc(wdb_pkg::IDX_CON0);
    wr(wdb_pkg::IDX_STR, 32'h4A);
    wr(wdb_pkg::IDX_CON1, 32'h02);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      data_src[0] <= k[0];
      repeat (8) @(negedge core_clk);
      `CHK(out_lvl, k ? 4'hC : 4'h6)
    end
    // the load request clears on the next rising data edge
    mdl[wdb_pkg::IDX_CON0] = 32'h80;
    rdc(wdb_pkg::IDX_CON0);
    `CHK(overlap_cnt, 0)
    // other resets keep both counts, clear STR and set both shutdown states to tri-state
    wr(wdb_pkg::IDX_DBR, 32'h2A);
    wr(wdb_pkg::IDX_DBF, 32'h15);
    wr(wdb_pkg::IDX_STR, 32'hA5);
    @(posedge core_clk);
    soft_rstn <= 1'b0;
    @(posedge core_clk);
    soft_rstn <= 1'b1;
    mdl[wdb_pkg::IDX_STR] = 0;
    mdl[wdb_pkg::IDX_AS0] = 32'h14;
    rdc(wdb_pkg::IDX_DBR);
    rdc(wdb_pkg::IDX_DBF);
    rdc(wdb_pkg::IDX_STR);
    rdc(wdb_pkg::IDX_AS0);
    final_report();
  end
endmodule

`undef CHK
`default_nettype wire
